// File: dv/adcctl_macro_model.sv
// converter macro model
`timescale 1ns/1ns
`default_nettype none
module adcctl_macro_model (
    input wire logic pclk, // clock
    input wire logic en_in, // out of reset
    input wire logic start_in, // launch
    input wire logic [9:0] sample_in, // value to return
    output logic done_out, // done level
    output logic [9:0] value_out // result
);
    int cnt = 0; // cycles since launch
    initial done_out = 1'b0;
    initial value_out = 10'h000;
    // reset while disabled; a launch drops done until the sample lands
    always @(posedge pclk) begin
        done_out <= en_in && !start_in && (done_out || cnt == 6);
        cnt <= !en_in ? 0 : start_in ? 1 : (cnt == 0 || cnt == 6) ? 0 : cnt + 1;
        if (cnt == 6) value_out <= sample_in;
    end
endmodule
`default_nettype wire

// File: dv/adcctl_properties.sv
// port checks for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcctl_properties
    import adcctl_pkg::*;
(
    input wire logic pclk, presetn, psel, penable, pwrite, pready, conversion_done_in, // bus
    input wire logic [ADDR_W-1:0] paddr, // address
    input wire logic [31:0] pwdata, prdata, // data
    input wire logic regulator_force_zero, midscale_sample, single_ended_select, converter_clock_select, // fields
    input wire logic constant_load_enable, dynamic_load_enable, triple_attenuator_enable, // options
    input wire logic converter_enable, conversion_start, second_pair_select, done_irq, // control
    input wire logic [3:0] input_select // mux code
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire wr = psel && penable && pready && pwrite; // write lands
    logic [31:0] wd_q; // last write data
    always_ff @(posedge pclk) if (wr) wd_q <= pwdata;
    ctrl_fields_a:
    assert property (wr && paddr == 8'h00 |-> ##2 {regulator_force_zero, midscale_sample, single_ended_select,
        converter_clock_select, input_select} == {wd_q[15], wd_q[12:11], wd_q[3], wd_q[9:6]}) else $error("ctrl");
    ctrl2_fields_a:
    assert property (wr && paddr == 8'h08 |-> ##2 {constant_load_enable, dynamic_load_enable,
        triple_attenuator_enable} == wd_q[3:1]) else $error("ctrl2");
    pair_select_a:
    assert property (second_pair_select == (!$past(single_ended_select) && $past(input_select) != 4'h0))
        else $error("pair");
    mask_gate_a:
    assert property (wr && paddr == 8'h00 && !pwdata[5] |=> !done_irq) else $error("mask");
    flag_sticky_a:
    assert property (done_irq && !wr |=> done_irq) else $error("irq dropped");
    clear_write_a:
    assert property ($stable(conversion_done_in) [*5] ##0 (wr && paddr == 8'h20) |=> !done_irq) else $error("clr");
    clear_read_a:
    assert property (pready && !pwrite && paddr == 8'h20 |-> prdata == 32'h0) else $error("clr read");
    start_pulse_a:
    assert property (conversion_start |=> !conversion_start) else $error("start long");
    start_enabled_a:
    assert property (conversion_start |-> converter_enable) else $error("start off");
    cover property (conversion_start);
    cover property (wr && paddr == 8'h20);
    cover property ($rose(done_irq));
endmodule
bind adcctl_top adcctl_properties chk_u (.*);
`default_nettype wire

// File: dv/adcctl_top_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcctl_top_test;
    import adcctl_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // master
    logic [ADDR_W-1:0] paddr = '0; // address
    logic [31:0] pwdata = '0, prdata, rd; // data
    logic pready, pslverr, err, conversion_done_in, regulator_enable, regulator_force_zero, converter_enable;
    logic conversion_start, midscale_sample, single_ended_select, polarity_invert, second_pair_select;
    logic converter_clock_select, constant_load_enable, dynamic_load_enable, triple_attenuator_enable, done_irq;
    logic [3:0] input_select; // mux code
    logic [9:0] result_value_in, positive_offset_trim, negative_offset_trim, sample = 10'h2A7; // data
    int miscompares = 0, checks_done = 0, starts = 0; // tallies
    adcctl_top dut_u (.*);
    adcctl_macro_model model_u (.pclk, .en_in(converter_enable), .start_in(conversion_start),
        .sample_in(sample), .done_out(conversion_done_in), .value_out(result_value_in));
    initial forever #50 pclk = ~pclk;
    // count launch pulses seen by the macro
    always @(posedge pclk) if (conversion_start === 1'b1) starts <= starts + 1;
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // one transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, '0);
        chk(nm, ex, rd);
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 60 && done_irq !== 1'b1; n++) @(posedge pclk);
        chk("irq", 1, done_irq);
    endtask
    task automatic t_reset;
        rdchk("ctrl", 8'h00, 0);
        rdchk("ctrl2", 8'h08, 0);
        rdchk("delay2", 8'h38, 32'h8880);
        rdchk("offp", 8'h10, 32'h200);
        chk("trim", 32'h200, negative_offset_trim);
    endtask
    task automatic t_fields;
        apb(1'b1, 8'h00, 32'hFFFF_FFFC);
        rdchk("ctrl", 8'h00, 32'hFFE8);
        chk("sign", 1, polarity_invert);
        apb(1'b1, 8'h00, 32'h0040);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        repeat (20) @(posedge pclk);
        rdchk("ctrl2", 8'h08, 32'hF);
        apb(1'b1, 8'h08, 0);
        rdchk("clr", 8'h20, 0);
        apb(1'b1, 8'h04, 32'h1);
        chk("slverr", 1, err);
    endtask
    task automatic t_conv;
        apb(1'b1, 8'h00, 32'h0002);
        repeat (12) @(posedge pclk);
        chk("starts", 0, starts);
        apb(1'b1, 8'h00, 32'h0021);
        apb(1'b1, 8'h00, 32'h0023);
        wait_irq;
        rdchk("ctrl", 8'h00, 32'h0031);
        rdchk("result", 8'h28, 32'h2A7);
        apb(1'b1, 8'h00, 32'h0001);
        chk("masked", 0, done_irq);
        rdchk("ctrl", 8'h00, 32'h0011);
        apb(1'b1, 8'h20, 32'h0);
        rdchk("ctrl", 8'h00, 32'h0001);
        sample = 10'h0C4;
        apb(1'b1, 8'h00, 32'h2023);
        wait_irq;
        chk("starts", 3, starts);
        rdchk("result", 8'h28, 32'h0C4);
    endtask
    // delayed bring-up: regulator first, then enable, start held until the last step
    task automatic t_delay;
        apb(1'b1, 8'h20, 0);
        apb(1'b1, 8'h30, 32'h1);
        apb(1'b1, 8'h38, 32'h0202);
        apb(1'b1, 8'h00, 32'h4021);
        apb(1'b1, 8'h08, 32'h1);
        @(posedge pclk);
        chk("gated", 0, {regulator_enable, converter_enable});
        for (int n = 0; n < 40 && converter_enable !== 1'b1; n++) @(posedge pclk);
        chk("en", 1, converter_enable);
        chk("regen", 1, regulator_enable);
        apb(1'b1, 8'h00, 32'h4023);
        wait_irq;
        chk("starts", 4, starts);
        rdchk("ctrl2", 8'h08, 32'h1);
    endtask
    task automatic complete_run;
        if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_fields;
        t_conv;
        t_delay;
        complete_run;
    end
    // watchdog well past the few hundred cycles the tests need
    initial begin
        #400000;
        miscompares++;
        complete_run;
    end
endmodule
`default_nettype wire

// File: verilog/adcctl_pkg.sv
// shared constants, types and decode helper for the converter control block
package adcctl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // printed register positions; the bus address of each is four times its index
    localparam logic [31:0] PRT_CTRL = 32'h50001500;
    localparam logic [31:0] PRT_CTRL2 = 32'h50001502;
    localparam logic [31:0] PRT_OFFP = 32'h50001504;
    localparam logic [31:0] PRT_OFFN = 32'h50001506;
    localparam logic [31:0] PRT_CLRINT = 32'h50001508;
    localparam logic [31:0] PRT_RESULT = 32'h5000150A;
    localparam logic [31:0] PRT_DELAY = 32'h5000150C;
    localparam logic [31:0] PRT_DELAY2 = 32'h5000150E;
    localparam int ADDR_W = 8;
    localparam logic [3:0] IDX_CTRL = 4'((PRT_CTRL - PRT_CTRL));
    localparam logic [3:0] IDX_CTRL2 = 4'((PRT_CTRL2 - PRT_CTRL));
    localparam logic [3:0] IDX_OFFP = 4'((PRT_OFFP - PRT_CTRL));
    localparam logic [3:0] IDX_OFFN = 4'((PRT_OFFN - PRT_CTRL));
    localparam logic [3:0] IDX_CLRINT = 4'((PRT_CLRINT - PRT_CTRL));
    localparam logic [3:0] IDX_RESULT = 4'((PRT_RESULT - PRT_CTRL));
    localparam logic [3:0] IDX_DELAY = 4'((PRT_DELAY - PRT_CTRL));
    localparam logic [3:0] IDX_DELAY2 = 4'((PRT_DELAY2 - PRT_CTRL));

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_FORCE0 = 15;
    localparam int B_REGEN = 14;
    localparam int B_CHOP = 13;
    localparam int B_MUTE = 12;
    localparam int B_SE = 11;
    localparam int B_SIGN = 10;
    localparam int B_SEL_HI = 9;
    localparam int B_SEL_LO = 6;
    localparam int B_MASK = 5;
    localparam int B_FLAG = 4;
    localparam int B_CLKSEL = 3;
    localparam int B_START = 1;
    localparam int B_EN = 0;
    localparam int B2_I20U = 3;
    localparam int B2_IDYN = 2;
    localparam int B2_ATTN = 1;
    localparam int B2_DLYEN = 0;
    localparam int TRIM_W = 10;
    localparam int RES_W = 10;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [9:0] TRIM_RST = 10'h200;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [15:0] DELAY2_RST = 16'h8880;
    localparam logic [3:0] SEL_FIRST_PAIR = 4'h0;

    // ------------------------------------------------------------
    // timing: one delay step is 125 ns rounded up to whole clocks, two cycles at 100 ns
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int DELAY_STEP_NS = 125;
    localparam int DELAY_STEP_CYC_I = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] DELAY_STEP_LAST = 2'(DELAY_STEP_CYC_I - 1);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_FIRST = 2'b01,
        CV_SECOND = 2'b10
    } adcctl_conv_e;

    typedef enum logic [2:0] {
        SQ_OFF = 3'b000,
        SQ_LDO_WAIT = 3'b001,
        SQ_EN_WAIT = 3'b010,
        SQ_START_WAIT = 3'b011,
        SQ_DONE = 3'b100
    } adcctl_seq_e;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic force0;
        logic reg_en;
        logic chop;
        logic mute;
        logic se;
        logic sign;
        logic [3:0] sel;
        logic mask;
        logic flag;
        logic clksel;
        logic start;
        logic en;
        logic i20u;
        logic idyn;
        logic attn;
        logic dly_en;
        logic [9:0] offp;
        logic [9:0] offn;
        logic [15:0] dly1;
        logic [15:0] dly2;
        logic [9:0] result;
        logic [9:0] first;
        adcctl_conv_e conv;
        adcctl_seq_e seq;
        logic [7:0] seq_cnt;
        logic [1:0] tick_cnt;
        logic s1;
        logic s2;
        logic s3;
        logic done_lvl;
        logic out_regen;
        logic out_en;
        logic out_start;
        logic out_sign;
        logic out_pair;
        logic irq;
    } adcctl_state_s;

    // map a bus address to a register index; valid only on aligned mapped words
    function automatic logic adcctl_decode(input logic [ADDR_W-1:0] a, output logic [3:0] idx);
        idx = a[5:2];
        adcctl_decode = (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == 2'h0) && (a[2] == 1'b0);
    endfunction

endpackage

// File: verilog/adcctl_top.sv
// converter control register block with apb slave and conversion sequencer
// Operation
// - force-zero bit grounds regulator output
// - chop takes two opposite-sign samples, averaged
// - mute bit samples mid-scale instead
// - se bit picks differential or single ended
// - sign bit inverts input and output polarity
// - input select programmed before start; reserved codes
// - differential: code zero first pair, else second
// - mask bit gates done interrupt
// - done flag sticky until clear register written
// - clock select bit picks converter clock
// - start launches conversion, self-clears, sets flag
// - enable zero holds converter disabled and reset
// - constant load bit adds regulator load
// - dynamic load bit enables regulator load
// - attenuator bit selects input range
// - delayed sequence enable never auto-cleared
// - any clear-register write clears flag; reads zero
// - result register holds last ten-bit value
// - delayed bring-up: regulator, enable, then start
`timescale 1ns/1ns
`default_nettype none

module adcctl_top
    import adcctl_pkg::*;
(
    input wire logic pclk, // system clock, 10 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high = write
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic conversion_done_in, // macro done level, asynchronous
    input wire logic [RES_W-1:0] result_value_in, // macro result, stable at done
    output logic regulator_enable, // regulator on
    output logic regulator_force_zero, // regulator output forced to zero
    output logic converter_enable, // converter out of reset
    output logic conversion_start, // one-cycle launch pulse to the macro
    output logic midscale_sample, // sample mid-scale
    output logic single_ended_select, // high = single ended mode
    output logic polarity_invert, // sign inversion for current sample
    output logic [3:0] input_select, // input multiplexer code
    output logic second_pair_select, // differential: second pin pair
    output logic converter_clock_select, // high = digital system clock
    output logic constant_load_enable, // fixed regulator load
    output logic dynamic_load_enable, // dynamic regulator load
    output logic triple_attenuator_enable, // extended input range
    output logic [TRIM_W-1:0] positive_offset_trim, // positive array trim
    output logic [TRIM_W-1:0] negative_offset_trim, // negative array trim
    output logic done_irq // interrupt to the interrupt controller
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    adcctl_state_s st_r; // all registered state
    adcctl_state_s st_nxt; // next value of the state

    // ------------------------------------------------------------
    // output wiring, every output is a field of the state register
    // ------------------------------------------------------------
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign regulator_enable = st_r.out_regen;
    assign converter_enable = st_r.out_en;
    assign conversion_start = st_r.out_start;
    assign polarity_invert = st_r.out_sign;
    assign second_pair_select = st_r.out_pair;
    assign done_irq = st_r.irq;
    assign input_select = st_r.sel;
    assign positive_offset_trim = st_r.offp;
    assign negative_offset_trim = st_r.offn;

    assign regulator_force_zero = st_r.force0;
    assign midscale_sample = st_r.mute;
    assign single_ended_select = st_r.se;
    assign converter_clock_select = st_r.clksel;
    assign constant_load_enable = st_r.i20u;
    assign dynamic_load_enable = st_r.idyn;
    assign triple_attenuator_enable = st_r.attn;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // bus, sequencer and conversion control in one pass; order matters:
    // hardware clears come first so that a software set in the same cycle wins,
    // and the software flag clear comes before the hardware set
    always_comb begin
        logic hit; // address decodes to a mapped word
        logic [3:0] idx; // register index
        logic wr_acc; // write takes effect this edge
        logic done_evt; // completion seen after synchroniser
        logic eff_regen; // regulator enable after gating
        logic eff_en; // converter enable after gating
        logic start_ok; // bring-up complete
        logic tick; // one delay step elapsed
        logic [10:0] sum; // two-sample sum
        logic [7:0] target; // delay of current bring-up step
        hit = 1'b0;
        idx = 4'h0;
        wr_acc = 1'b0;
        done_evt = 1'b0;
        eff_regen = 1'b0;
        eff_en = 1'b0;
        start_ok = 1'b0;
        tick = 1'b0;
        sum = 11'h000;
        target = 8'h00;
        st_nxt = st_r;

        // done input: three flops, change counts when the last two agree
        st_nxt.s1 = conversion_done_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.done_lvl = st_r.s3;
            done_evt = st_r.s3 && !st_r.done_lvl;
        end

        // apb decode, used in both phases since the master holds paddr
        hit = adcctl_decode(paddr, idx);
        wr_acc = psel && penable && st_r.pready && pwrite && hit;

        // any write to clear register drops flag
        if (wr_acc && (idx == IDX_CLRINT)) begin
            st_nxt.flag = 1'b0;
        end

        // ------------------------------------------------------------
        // delayed bring-up sequencer
        // ------------------------------------------------------------
        // step timebase, only runs while a bring-up is in progress
        if (st_r.seq != SQ_OFF && st_r.seq != SQ_DONE) begin
            if (st_r.tick_cnt == DELAY_STEP_LAST) begin
                st_nxt.tick_cnt = 2'h0;
                tick = 1'b1;
            end else begin
                st_nxt.tick_cnt = st_r.tick_cnt + 2'h1;
            end
        end else begin
            st_nxt.tick_cnt = 2'h0;
        end
        case (st_r.seq)
            SQ_LDO_WAIT: target = st_r.dly1[7:0];
            SQ_EN_WAIT: target = st_r.dly2[7:0];
            SQ_START_WAIT: target = st_r.dly2[15:8];
            default: target = 8'h00;
        endcase
        // steps advance after each programmed delay
        case (st_r.seq)
            SQ_OFF: begin
                st_nxt.seq_cnt = 8'h00;
            end
            SQ_LDO_WAIT: begin
                if (st_r.seq_cnt >= target) begin
                    st_nxt.seq = SQ_EN_WAIT;
                    st_nxt.seq_cnt = 8'h00;
                end else if (tick) begin
                    st_nxt.seq_cnt = st_r.seq_cnt + 8'h01;
                end
            end
            SQ_EN_WAIT: begin
                if (st_r.seq_cnt >= target) begin
                    st_nxt.seq = SQ_START_WAIT;
                    st_nxt.seq_cnt = 8'h00;
                end else if (tick) begin
                    st_nxt.seq_cnt = st_r.seq_cnt + 8'h01;
                end
            end
            SQ_START_WAIT: begin
                if (st_r.seq_cnt >= target) begin
                    st_nxt.seq = SQ_DONE;
                    st_nxt.seq_cnt = 8'h00;
                end else if (tick) begin
                    st_nxt.seq_cnt = st_r.seq_cnt + 8'h01;
                end
            end
            SQ_DONE: begin
                st_nxt.seq_cnt = 8'h00;
            end
            default: begin
                st_nxt.seq = SQ_OFF;
            end
        endcase
        // gating: without the delay function the bits act at once
        if (st_r.dly_en) begin
            eff_regen = st_r.reg_en && (st_r.seq >= SQ_EN_WAIT);
            eff_en = st_r.en && (st_r.seq >= SQ_START_WAIT);
            start_ok = (st_r.seq == SQ_DONE);
        end else begin
            eff_regen = st_r.reg_en;
            eff_en = st_r.en;
            start_ok = 1'b1;
        end
        st_nxt.out_regen = eff_regen;
        st_nxt.out_en = eff_en;

        // ------------------------------------------------------------
        // conversion control
        // ------------------------------------------------------------
        st_nxt.out_start = 1'b0;
        st_nxt.out_pair = !st_r.se && (st_r.sel != SEL_FIRST_PAIR);
        // disabled converter aborts and holds idle
        if (!eff_en) begin
            st_nxt.conv = CV_IDLE;
            st_nxt.start = 1'b0;
            st_nxt.out_sign = st_r.sign;
        end else begin
            case (st_r.conv)
                CV_IDLE: begin
                    st_nxt.out_sign = st_r.sign;
                    if (st_r.start && start_ok) begin
                        st_nxt.out_start = 1'b1;
                        st_nxt.conv = CV_FIRST;
                    end
                end
                CV_FIRST: begin
                    if (done_evt) begin
                        if (st_r.chop) begin
                            st_nxt.first = result_value_in;
                            st_nxt.out_sign = !st_r.sign;
                            st_nxt.out_start = 1'b1;
                            st_nxt.conv = CV_SECOND;
                        end else begin
                            st_nxt.result = result_value_in;
                            st_nxt.start = 1'b0;
                            st_nxt.flag = 1'b1;
                            st_nxt.conv = CV_IDLE;
                        end
                    end
                end
                CV_SECOND: begin
                    if (done_evt) begin
                        sum = {1'b0, st_r.first} + {1'b0, result_value_in};
                        st_nxt.result = sum[10:1];
                        st_nxt.start = 1'b0;
                        st_nxt.flag = 1'b1;
                        st_nxt.conv = CV_IDLE;
                        st_nxt.out_sign = st_r.sign;
                    end
                end
                default: begin
                    st_nxt.conv = CV_IDLE;
                end
            endcase
        end

        // ------------------------------------------------------------
        // apb slave: no wait state, answer registered in setup
        // ------------------------------------------------------------
        if (psel && !penable) begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !hit;
            st_nxt.prdata = 32'h00000000;
            if (!pwrite && hit) begin
                if (idx == IDX_CTRL) begin
                    st_nxt.prdata[B_FORCE0] = st_r.force0;
                    st_nxt.prdata[B_REGEN] = st_r.reg_en;
                    st_nxt.prdata[B_CHOP] = st_r.chop;
                    st_nxt.prdata[B_MUTE] = st_r.mute;
                    st_nxt.prdata[B_SE] = st_r.se;
                    st_nxt.prdata[B_SIGN] = st_r.sign;
                    st_nxt.prdata[B_SEL_HI:B_SEL_LO] = st_r.sel;
                    st_nxt.prdata[B_MASK] = st_r.mask;
                    st_nxt.prdata[B_FLAG] = st_r.flag;
                    st_nxt.prdata[B_CLKSEL] = st_r.clksel;
                    st_nxt.prdata[B_START] = st_r.start;
                    st_nxt.prdata[B_EN] = st_r.en;
                end else if (idx == IDX_CTRL2) begin
                    st_nxt.prdata[B2_I20U] = st_r.i20u;
                    st_nxt.prdata[B2_IDYN] = st_r.idyn;
                    st_nxt.prdata[B2_ATTN] = st_r.attn;
                    st_nxt.prdata[B2_DLYEN] = st_r.dly_en;
                end else if (idx == IDX_OFFP) begin
                    st_nxt.prdata[TRIM_W-1:0] = st_r.offp;
                end else if (idx == IDX_OFFN) begin
                    st_nxt.prdata[TRIM_W-1:0] = st_r.offn;
                end else if (idx == IDX_RESULT) begin
                    st_nxt.prdata[RES_W-1:0] = st_r.result;
                end else if (idx == IDX_DELAY) begin
                    st_nxt.prdata[15:0] = st_r.dly1;
                end else if (idx == IDX_DELAY2) begin
                    st_nxt.prdata[15:0] = st_r.dly2;
                end else begin
                    st_nxt.prdata = 32'h00000000;
                end
            end
        end else if (psel && penable && st_r.pready) begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end

        // register writes at the access edge; flag and test bit are not writable
        if (wr_acc) begin
            if (idx == IDX_CTRL) begin
                st_nxt.force0 = pwdata[B_FORCE0];
                st_nxt.reg_en = pwdata[B_REGEN];
                st_nxt.chop = pwdata[B_CHOP];
                st_nxt.mute = pwdata[B_MUTE];
                st_nxt.se = pwdata[B_SE];
                st_nxt.sign = pwdata[B_SIGN];
                st_nxt.sel = pwdata[B_SEL_HI:B_SEL_LO];
                st_nxt.mask = pwdata[B_MASK];
                st_nxt.clksel = pwdata[B_CLKSEL];
                st_nxt.en = pwdata[B_EN];
                // writing zero cannot abort a running conversion
                if (pwdata[B_START]) begin
                    st_nxt.start = 1'b1;
                end
            end else if (idx == IDX_CTRL2) begin
                st_nxt.i20u = pwdata[B2_I20U];
                st_nxt.idyn = pwdata[B2_IDYN];
                st_nxt.attn = pwdata[B2_ATTN];
                st_nxt.dly_en = pwdata[B2_DLYEN];
                if (pwdata[B2_DLYEN] && !st_r.dly_en) begin
                    st_nxt.seq = SQ_LDO_WAIT;
                    st_nxt.seq_cnt = 8'h00;
                end else if (!pwdata[B2_DLYEN]) begin
                    st_nxt.seq = SQ_OFF;
                end
            end else if (idx == IDX_OFFP) begin
                st_nxt.offp = pwdata[TRIM_W-1:0];
            end else if (idx == IDX_OFFN) begin
                st_nxt.offn = pwdata[TRIM_W-1:0];
            end else if (idx == IDX_DELAY) begin
                st_nxt.dly1 = pwdata[15:0];
            end else if (idx == IDX_DELAY2) begin
                st_nxt.dly2 = pwdata[15:0];
            end
        end

        // line equals flag and mask, same edge
        st_nxt.irq = st_nxt.flag && st_nxt.mask;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // control fields start at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.conv <= CV_IDLE;
            st_r.seq <= SQ_OFF;
            st_r.offp <= TRIM_RST;
            st_r.offn <= TRIM_RST;
            st_r.dly1 <= DELAY_RST;
            st_r.dly2 <= DELAY2_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire
